/* mtcg_regs.svh */
// constants for the memory transfer check generator
// Behaviour
// - top ROM byte holds 8-bit check over lower 56 bits, poly x8+x5+x4+1.
// - ROM check byte is sent uninverted; fixed at manufacture, not computed.
// - memory check uses 16-bit generator, poly x16+x15+x2+1, reads and writes.
// - 16-bit check value is always sent inverted.
// - on reads, check value is sent after the last byte of each 8-byte page.
// - first read pass: clear, shift command, addresses, data to page end.
// - later read passes: clear, shift only that page's data bytes.
// - on writes, check value is sent before the data byte is committed.
// - first write pass: clear, shift command, low and high address, data byte.
// - address auto-increments; next write pass loads address, then shifts data.
// - after a write check value, the data byte is echoed to the master.
`ifndef MTCG_REGS_SVH
`define MTCG_REGS_SVH
`define MTCG_CMD_WRITE 8'h55
`define MTCG_CMD_READ 8'hAA
`define MTCG_CRC16_POLY 16'hA001
`define MTCG_CRC8_POLY 8'h8C
`define MTCG_CRC16_INIT 16'h0000
`define MTCG_PAGE_LAST 3'h7
`define MTCG_ROM_CRC_LSB 56
`endif

/* mtcg_pkg.sv */
// types of the memory transfer check generator
package mtcg_pkg;
    typedef enum logic [6:0] {
        MTCG_IDLE = 7'b0000001,
        MTCG_ADDR_LO = 7'b0000010,
        MTCG_ADDR_HI = 7'b0000100,
        MTCG_RD_DATA = 7'b0001000,
        MTCG_WR_DATA = 7'b0010000,
        MTCG_SEND_CRC = 7'b0100000,
        MTCG_ECHO = 7'b1000000
    } mtcg_state_e;
    typedef enum logic [1:0] {
        MTCG_OP_NONE = 2'h0,
        MTCG_OP_CLEAR = 2'h1,
        MTCG_OP_SHIFT = 2'h2,
        MTCG_OP_LOAD = 2'h3
    } mtcg_op_e;
endpackage : mtcg_pkg

/* mtcg_crc_if.sv */
// operation port between sequencer and the 16-bit generator
`timescale 1ns/1ps
interface mtcg_crc_if;
    import mtcg_pkg::*;
    mtcg_op_e op;
    logic [15:0] load_val;
    logic [7:0] byte_in;
    logic [15:0] crc;
    modport ctrl (output op, output load_val, output byte_in, input crc);
    modport gen (input op, input load_val, input byte_in, output crc);
endinterface : mtcg_crc_if

/* mtcg_crc16.sv */
// 16-bit check generator, one byte per cycle
`timescale 1ns/1ps
`include "mtcg_regs.svh"
module mtcg_crc16
    import mtcg_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    mtcg_crc_if.gen port
);
    typedef struct packed {
        logic [15:0] crc;
    } mtcg_gen_s;
    mtcg_gen_s st, next_st;

    // reflected form: lsb first, same result as the serial shifter
    function automatic logic [15:0] mtcg_shift_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (r[0] ^ d[i]) begin
                r = (r >> 1) ^ `MTCG_CRC16_POLY;
            end else begin
                r = r >> 1;
            end
        end
        return r;
    endfunction : mtcg_shift_byte

    always_comb begin
        next_st = st;
        case (port.op)
            MTCG_OP_CLEAR: next_st.crc = `MTCG_CRC16_INIT;
            MTCG_OP_SHIFT: next_st.crc = mtcg_shift_byte(st.crc, port.byte_in);
            MTCG_OP_LOAD: next_st.crc = port.load_val;
            default: next_st = st;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.crc = st.crc;
endmodule : mtcg_crc16

/* mtcg_top.sv */
// memory transfer sequencer with check value generation
`timescale 1ns/1ps
`include "mtcg_regs.svh"
module mtcg_top
    import mtcg_pkg::*;
#(
    parameter logic [63:0] ROM_ID = 64'h0000_0000_0000_0001
)
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic bus_reset,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_ready,
    input wire logic [7:0] mem_rdata,
    input wire logic rom_req,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic [15:0] mem_addr,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    output logic busy
);
    // every output is a field here, so each leaves the block from a flop
    typedef struct packed {
        mtcg_state_e state;
        logic is_write;
        logic first_pass;
        logic [15:0] addr;
        logic [7:0] data;
        logic crc_hi;
        logic echo_pend;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic mem_we;
        logic [7:0] mem_wdata;
        logic [2:0] rom_idx;
        logic rom_active;
        logic busy;
    } mtcg_top_s;
    mtcg_top_s st, next_st;

    // one generator shared by the read and write paths
    mtcg_crc_if cif ();
    mtcg_crc16 u_crc (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .port(cif)
    );

    // factory-fixed check byte over the low 56 id bits
    function automatic logic [7:0] mtcg_rom_crc(input logic [55:0] id);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            if (c[0] ^ id[i]) begin
                c = (c >> 1) ^ `MTCG_CRC8_POLY;
            end else begin
                c = c >> 1;
            end
        end
        return c;
    endfunction : mtcg_rom_crc

    // elaboration-time constant: fixed, never computed by running logic
    localparam logic [63:0] ROM_FULL = {mtcg_rom_crc(ROM_ID[55:0]), ROM_ID[55:0]};

    // both command codes open a pass; anything else is ignored in idle
    function automatic logic mtcg_is_cmd(input logic [7:0] b);
        return (b == `MTCG_CMD_WRITE) || (b == `MTCG_CMD_READ);
    endfunction : mtcg_is_cmd

    // last byte of an 8-byte page ends a read pass
    function automatic logic mtcg_page_end(input logic [15:0] a);
        return a[2:0] == `MTCG_PAGE_LAST;
    endfunction : mtcg_page_end

    // a held byte frees its slot in the very cycle the link takes it
    logic tx_free;
    assign tx_free = !st.tx_valid || tx_ready;

    always_comb begin
        next_st = st;
        next_st.mem_we = 1'b0;
        // counter steps after the pulse, so mem_addr holds the write address during it
        if (st.mem_we) begin
            next_st.addr = st.addr + 16'h0001;
        end
        cif.op = MTCG_OP_NONE;
        cif.load_val = st.addr;
        cif.byte_in = rx_byte;
        if (st.tx_valid && tx_ready) begin
            next_st.tx_valid = 1'b0;
        end
        // bus reset outranks an offered byte and any pass in flight
        if (bus_reset) begin
            next_st.state = MTCG_IDLE;
            next_st.rom_active = 1'b0;
            next_st.tx_valid = 1'b0;
            cif.op = MTCG_OP_CLEAR;
        end else if (st.rom_active) begin
            if (tx_free) begin
                next_st.tx_valid = 1'b1;
                next_st.tx_byte = ROM_FULL[8*st.rom_idx +: 8];
                next_st.rom_idx = st.rom_idx + 3'h1;
                if (st.rom_idx == 3'h7) begin
                    next_st.rom_active = 1'b0;
                end
            end
        end else begin
            case (st.state)
                MTCG_IDLE: begin
                    if (rom_req) begin
                        next_st.rom_active = 1'b1;
                        next_st.rom_idx = 3'h0;
                    end else if (rx_valid && mtcg_is_cmd(rx_byte)) begin
                        next_st.is_write = (rx_byte == `MTCG_CMD_WRITE);
                        next_st.first_pass = 1'b1;
                        next_st.state = MTCG_ADDR_LO;
                        cif.op = MTCG_OP_SHIFT; // clear is implied by idle reset below
                    end
                end
                MTCG_ADDR_LO: begin
                    if (rx_valid) begin
                        next_st.addr[7:0] = rx_byte;
                        next_st.state = MTCG_ADDR_HI;
                        cif.op = MTCG_OP_SHIFT;
                    end
                end
                MTCG_ADDR_HI: begin
                    if (rx_valid) begin
                        next_st.addr[15:8] = rx_byte;
                        next_st.state = st.is_write ? MTCG_WR_DATA : MTCG_RD_DATA;
                        cif.op = MTCG_OP_SHIFT;
                    end
                end
                MTCG_RD_DATA: begin
                    // reads run on until a bus reset; the host decides when to stop
                    if (tx_free) begin
                        next_st.tx_valid = 1'b1;
                        next_st.tx_byte = mem_rdata;
                        cif.op = MTCG_OP_SHIFT;
                        cif.byte_in = mem_rdata;
                        next_st.addr = st.addr + 16'h0001;
                        if (mtcg_page_end(st.addr)) begin
                            next_st.state = MTCG_SEND_CRC;
                            next_st.crc_hi = 1'b0;
                        end
                    end
                end
                MTCG_WR_DATA: begin
                    // first pass shifts onto command and address, later ones onto the load
                    if (rx_valid) begin
                        next_st.data = rx_byte;
                        cif.op = st.first_pass ? MTCG_OP_SHIFT : MTCG_OP_NONE;
                        next_st.state = MTCG_SEND_CRC;
                        next_st.crc_hi = 1'b0;
                        next_st.echo_pend = 1'b1;
                    end
                end
                MTCG_SEND_CRC: begin
                    // low half first, both halves inverted
                    if (tx_free) begin
                        next_st.tx_valid = 1'b1;
                        next_st.tx_byte = st.crc_hi ? ~cif.crc[15:8] : ~cif.crc[7:0];
                        next_st.crc_hi = 1'b1;
                        if (st.crc_hi) begin
                            next_st.first_pass = 1'b0;
                            if (st.is_write) begin
                                next_st.state = MTCG_ECHO;
                            end else begin
                                next_st.state = MTCG_RD_DATA;
                                cif.op = MTCG_OP_CLEAR;
                            end
                        end
                    end
                end
                MTCG_ECHO: begin
                    if (tx_free) begin
                        next_st.tx_valid = 1'b1;
                        next_st.tx_byte = st.data;
                        next_st.mem_we = 1'b1;
                        // echo and commit leave together, after both check bytes
                        next_st.mem_wdata = st.data;
                        next_st.state = MTCG_WR_DATA;
                        cif.op = MTCG_OP_LOAD;
                        cif.load_val = st.addr + 16'h0001;
                    end
                end
                default: next_st.state = MTCG_IDLE;
            endcase
        end
        // later write passes: shift the data byte after the address load
        if (!bus_reset && !st.rom_active && st.state == MTCG_WR_DATA && !st.first_pass
            && rx_valid) begin
            cif.op = MTCG_OP_SHIFT;
        end
        if (!bus_reset && !st.rom_active && st.state == MTCG_IDLE && !rx_valid) begin
            cif.op = MTCG_OP_CLEAR;
        end

        next_st.busy = (next_st.state != MTCG_IDLE) || next_st.rom_active;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            // full clear: counter, flags and every output to zero
            st <= '0;
            st.state <= MTCG_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign tx_valid = st.tx_valid;
    assign tx_byte = st.tx_byte;
    assign mem_addr = st.addr;
    assign mem_we = st.mem_we;
    assign mem_wdata = st.mem_wdata;
    assign busy = st.busy;
endmodule : mtcg_top

/* mtcg_master_model.sv */
// bus master model: sends bytes to the block, collects what it sends back
`timescale 1ns/1ps
module mtcg_master_model (
    input wire logic core_clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready
);
    logic [7:0] got[$];
    logic slow;
    initial begin
        slow = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
    end
    // slow mode stalls every other cycle
    always @(posedge core_clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_byte);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
    task send(input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b; // no stale byte once released
        @(posedge core_clk);
    endtask : send
endmodule : mtcg_master_model

/* mtcg_top_assertions.sv */
// port checker for the memory transfer check generator
`timescale 1ns/1ps
module mtcg_top_assertions (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic bus_reset,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic tx_ready,
    input wire logic rom_req,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    input wire logic busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence cmd_s;
        !busy && rx_valid && !bus_reset && (rx_byte == 8'h55 || rx_byte == 8'hAA);
    endsequence
    sequence other_s;
        !busy && rx_valid && !bus_reset && !rom_req && rx_byte != 8'h55 && rx_byte != 8'hAA;
    endsequence
    tx_hold_a: assert property (tx_valid && !tx_ready && !bus_reset |=>
        tx_valid && $stable(tx_byte)) else $error("tx byte dropped");
    commit_pulse_a: assert property (mem_we |=> !mem_we) else $error("long commit");
    cmd_start_a: assert property (cmd_s |=> busy) else $error("command ignored");
    cmd_refuse_a: assert property (other_s |=> !busy) else $error("bad command taken");
    reset_abandon_a: assert property (bus_reset |-> ##[1:2] !busy)
        else $error("bus reset ignored");
    echo_data_a: assert property (mem_we |-> ##[0:1] (tx_valid && tx_byte == mem_wdata))
        else $error("echo differs");
    commit_busy_a: assert property (mem_we |-> busy) else $error("commit while idle");
    rom_start_a: assert property (!busy && rom_req && !rx_valid && !bus_reset |=> busy)
        else $error("rom read ignored");
endmodule : mtcg_top_assertions
bind mtcg_top mtcg_top_assertions chk_u (.core_clk(core_clk), .arst_n(arst_n),
    .bus_reset(bus_reset), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready),
    .rom_req(rom_req), .tx_valid(tx_valid), .tx_byte(tx_byte), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .busy(busy));

/* mtcg_top_tb_top.sv */
// testbench for the memory transfer check generator
`timescale 1ns/1ps
module mtcg_top_tb_top;
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d,
        input logic [15:0] p);
        for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? p : 16'h0000);
        return c;
    endfunction : crc
    function automatic logic [7:0] rom8(input logic [55:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 7; i++) r = crc(r, v[8*i+:8], 16'h008C);
        return r[7:0];
    endfunction : rom8
    localparam logic [55:0] ID_LOW = 56'h00_A55A_3C1E_2807; // arbitrary value
    localparam logic [63:0] ROM = {rom8(ID_LOW), ID_LOW};
    logic core_clk;
    logic arst_n;
    logic bus_reset;
    logic rom_req;
    logic tx_valid, mem_we, busy, rx_valid, tx_ready;
    logic [7:0] tx_byte, mem_wdata, rx_byte, w_data, mem_rdata;
    logic [15:0] mem_addr, w_addr;
    int n_mismatch = 0;
    int tests_run = 0;
    assign mem_rdata = mem_addr[7:0] ^ 8'h5A;
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (mem_we === 1'b1) {w_addr, w_data} <= {mem_addr, mem_wdata};
    mtcg_master_model m (.core_clk(core_clk), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready));
    mtcg_top #(.ROM_ID(ROM)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .bus_reset(bus_reset), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_ready(tx_ready),
        .mem_rdata(mem_rdata), .rom_req(rom_req), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .busy(busy));
    task chk(input string s, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task take(input int n);
        for (int k = 0; k < 3000 && m.got.size() < n; k++) @(posedge core_clk);
        @(negedge core_clk);
        chk("byte count", n, m.got.size());
    endtask : take
    task bus_rst;
        bus_reset <= 1'b1;
        @(posedge core_clk);
        bus_reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("busy after bus reset", 0, busy);
        m.got.delete();
    endtask : bus_rst
    task t_write;
        logic [15:0] c;
        c = 16'h0000;
        c = crc(crc(crc(crc(c, 8'h55, 16'hA001), 8'h16, 16'hA001), 8'h00, 16'hA001), 8'h64,
            16'hA001);
        m.send(8'h55);
        m.send(8'h16);
        m.send(8'h00);
        m.send(8'h64);
        take(3);
        chk("write crc", ~c, {m.got[1], m.got[0]});
        chk("echo", 8'h64, m.got[2]);
        chk("commit", {16'h0016, 8'h64}, {w_addr, w_data});
        c = crc(16'h0017, 8'h96, 16'hA001);
        m.send(8'h96);
        take(6);
        chk("next crc", ~c, {m.got[4], m.got[3]});
        chk("echo next", 8'h96, m.got[5]);
        chk("commit next", {16'h0017, 8'h96}, {w_addr, w_data});
        bus_rst();
    endtask : t_write
    task t_read;
        logic [15:0] c;
        logic [7:0] q[$];
        c = crc(crc(crc(16'h0000, 8'hAA, 16'hA001), 8'h0E, 16'hA001), 8'h00, 16'hA001);
        for (int a = 14; a < 24; a++) begin
            q.push_back(a[7:0] ^ 8'h5A);
            c = crc(c, a[7:0] ^ 8'h5A, 16'hA001);
            if (a[2:0] == 3'h7) begin
                q.push_back(~c[7:0]);
                q.push_back(~c[15:8]);
                c = 16'h0000;
            end
        end
        m.slow <= 1'b1;
        m.send(8'hAA);
        m.send(8'h0E);
        m.send(8'h00);
        take(14);
        foreach (q[i]) chk("read stream", q[i], m.got[i]);
        m.slow <= 1'b0;
        bus_rst();
    endtask : t_read
    task t_misc;
        m.send(8'h3C);
        chk("busy on bad command", 0, busy);
        m.send(8'h55);
        m.send(8'h20);
        bus_rst();
        rom_req <= 1'b1;
        @(posedge core_clk);
        rom_req <= 1'b0;
        take(8);
        for (int i = 0; i < 8; i++) chk("rom byte", ROM[8*i+:8], m.got[i]);
        chk("rom check", rom8({m.got[6], m.got[5], m.got[4], m.got[3], m.got[2], m.got[1],
            m.got[0]}), m.got[7]);
        bus_rst();
    endtask : t_misc
    task t_reset;
        logic [15:0] c;
        c = crc(crc(crc(crc(16'h0000, 8'h55, 16'hA001), 8'h08, 16'hA001), 8'h00, 16'hA001),
            8'hC0, 16'hA001);
        m.send(8'hAA);
        m.send(8'h08);
        m.send(8'h00);
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b0;
        @(negedge core_clk);
        chk("busy in reset", 0, busy);
        chk("tx in reset", 0, {tx_valid, tx_byte});
        chk("addr in reset", 0, mem_addr);
        chk("commit in reset", 0, {mem_we, mem_wdata});
        @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        m.got.delete();
        m.send(8'h55);
        m.send(8'h08);
        m.send(8'h00);
        m.send(8'hC0);
        take(3);
        chk("write crc after reset", ~c, {m.got[1], m.got[0]});
        chk("commit after reset", {16'h0008, 8'hC0}, {w_addr, w_data});
    endtask : t_reset
    task results;
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        results();
    end
    initial begin
        arst_n = 1'b0;
        bus_reset = 1'b0;
        rom_req = 1'b0;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_misc();
        t_write();
        t_read();
        t_reset();
        results();
    end
endmodule : mtcg_top_tb_top
